// ---- wdt_pkg.sv ----
// Package of constants and types for the dual stage watchdog
package wdt_pkg;
	localparam int unsigned CLK_HZ           = 100_000_000;
	localparam int unsigned TICK_US          = 1000;
	localparam int unsigned TICK_CYCLES      = CLK_HZ / 1_000_000 * TICK_US;
	localparam logic [3:0]  ACT_OFF          = 4'h0;
	localparam logic [3:0]  ACT_RESET        = 4'h1;
	localparam logic [3:0]  ACT_DELAY        = 4'h5;
	localparam logic [3:0]  ACT_OUT          = 4'h8;
	localparam logic [3:0]  ACT_RESET_OUT    = 4'h9;
	localparam logic [3:0]  ACT_DELAY_OUT    = 4'hd;
	localparam logic [7:0]  OFF_CTRL         = 8'h00;
	localparam logic [7:0]  OFF_TIMEOUT1     = 8'h04;
	localparam logic [7:0]  OFF_TIMEOUT2     = 8'h08;
	localparam logic [7:0]  OFF_TRIGGER      = 8'h0c;
	localparam logic [7:0]  OFF_STATUS       = 8'h10;
	localparam logic [7:0]  OFF_IRQ_STATUS   = 8'h14;
	localparam logic [7:0]  OFF_IRQ_MASK     = 8'h18;
	localparam logic [7:0]  OFF_COUNT        = 8'h1c;
	localparam logic [31:0] TRIGGER_KEY      = 32'h0000_5a5a;
	localparam logic [31:0] TIMEOUT_RST      = 32'h0000_03e8;
	localparam int unsigned RESET_PULSE_CYC  = 16;
	localparam int unsigned CTRL_ACT1_LSB    = 0;
	localparam int unsigned CTRL_ACT2_LSB    = 4;
	localparam int unsigned CTRL_SEL_BIT     = 8;
	localparam int unsigned CTRL_EN_BIT      = 9;
	localparam logic [1:0]  RESP_OKAY        = 2'b00;
	localparam logic [1:0]  RESP_SLVERR      = 2'b10;
	typedef enum logic [1:0] {ST_IDLE, ST_STAGE1, ST_STAGE2, ST_DONE} wdt_state_t;
endpackage

// ---- wdt_tick_if.sv ----
// Interface carrying the time base tick between watchdog modules
`timescale 1ns/1ns
interface wdt_tick_if;
	logic tick;
	modport src (output tick);
	modport dst (input tick);
endinterface

// ---- wdt_prescaler.sv ----
// Time base divider producing a one cycle tick enable
`timescale 1ns/1ns
module wdt_prescaler
	import wdt_pkg::*;
#(
	parameter int unsigned DIV = TICK_CYCLES
) (
	input  wire logic mclk_in,
	input  wire logic arst_n_in,
	input  wire logic run_in,
	wdt_tick_if.src   tick_if
);
	if (DIV < 2) begin : g_div_check
		$error("DIV must be at least 2");
	end
	logic [31:0] cnt;
	wire         wrap = (cnt == 32'(DIV - 1));
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt         <= 32'h0;
			tick_if.tick <= 1'b0;
		end else begin
			cnt          <= (!run_in || wrap) ? 32'h0 : cnt + 32'h1;
			tick_if.tick <= run_in && wrap;
		end
	end
endmodule

// ---- dual_stage_watchdog.sv ----
// Dual stage watchdog timer with AXI4-Lite register slave
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
module dual_stage_watchdog
	import wdt_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_CYCLES
) (
	input  wire logic        mclk_in,
	input  wire logic        arst_n_in,
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	output logic             watchdog_out,
	output logic             module_reset_out,
	output logic             irq_out
);
	wdt_tick_if tick_if ();

	logic [31:0] ctrl;
	logic [31:0] timeout1;
	logic [31:0] timeout2;
	logic [2:0]  irq_status;
	logic [2:0]  irq_mask;
	logic [31:0] count;
	wdt_state_t  state;
	logic [7:0]  rst_cnt;
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	wire [3:0] act1   = ctrl[CTRL_ACT1_LSB +: 4];
	wire [3:0] act2   = ctrl[CTRL_ACT2_LSB +: 4];
	wire       sel2   = ctrl[CTRL_SEL_BIT];
	wire       enable = ctrl[CTRL_EN_BIT];

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) old[8*i +: 8] = nw[8*i +: 8];
		end
		return old;
	endfunction

	function automatic logic do_reset(input logic [3:0] act);
		return (act == ACT_RESET) || (act == ACT_RESET_OUT);
	endfunction

	function automatic logic do_out(input logic [3:0] act);
		return (act == ACT_OUT) || (act == ACT_RESET_OUT) || (act == ACT_DELAY_OUT);
	endfunction

	// Delay code is illegal in stage two, so it is treated as off there
	function automatic logic legal2(input logic [3:0] act);
		return (act != ACT_OFF) && (act != ACT_DELAY);
	endfunction

	wire wr_go   = aw_held && w_held && !s_axi_bvalid_out;
	wire wr_ctrl = wr_go && (aw_addr == OFF_CTRL);
	wire wr_t1   = wr_go && (aw_addr == OFF_TIMEOUT1);
	wire wr_t2   = wr_go && (aw_addr == OFF_TIMEOUT2);
	wire wr_irqs = wr_go && (aw_addr == OFF_IRQ_STATUS);
	wire wr_mask = wr_go && (aw_addr == OFF_IRQ_MASK);
	wire wr_trig = wr_go && (aw_addr == OFF_TRIGGER) && (w_data == TRIGGER_KEY);
	wire wr_hit  = (aw_addr == OFF_CTRL) || (aw_addr == OFF_TIMEOUT1) || (aw_addr == OFF_TIMEOUT2)
		|| (aw_addr == OFF_TRIGGER) || (aw_addr == OFF_IRQ_STATUS) || (aw_addr == OFF_IRQ_MASK);

	// Same gating as the sequencer, so no event fires for a discarded expiry
	wire expire  = tick_if.tick && (count <= 32'h1) && enable && (rst_cnt == 8'h0) && !wr_trig;
	wire exp1    = expire && (state == ST_STAGE1);
	wire exp2    = expire && (state == ST_STAGE2);
	wire [3:0] cur_act = (state == ST_STAGE1) ? act1 : act2;
	wire stage2_on = legal2(act2);
	wire fire_out  = expire && do_out(cur_act) && (sel2 ? exp2 : exp1);
	wire fire_rst  = expire && do_reset(cur_act);
	wire [2:0] evt = {fire_rst, fire_out, exp1 | exp2};

	wdt_prescaler #(
		.DIV (TICK_DIV)
	) u_prescaler (
		.mclk_in   (mclk_in),
		.arst_n_in (arst_n_in),
		.run_in    ((state == ST_STAGE1) || (state == ST_STAGE2)),
		.tick_if   (tick_if)
	);

	// Stage sequencer; a trigger restarts at stage one, or at stage two when act1 is off and stage2_on is set, else goes to ST_DONE
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= ST_IDLE;
			count <= 32'h0;
		end else if (!enable || (rst_cnt != 8'h0)) begin
			state <= ST_IDLE;
			count <= 32'h0;
		end else if (wr_trig || state == ST_IDLE) begin
			if (act1 != ACT_OFF) begin
				state <= ST_STAGE1;
				count <= timeout1;
			end else if (stage2_on) begin
				state <= ST_STAGE2;
				count <= timeout2;
			end else begin
				state <= ST_DONE;
			end
		end else if (tick_if.tick) begin
			unique case (state)
				ST_STAGE1: begin
					if (count <= 32'h1) begin
						state <= stage2_on ? ST_STAGE2 : ST_DONE;
						count <= timeout2;
					end else begin
						count <= count - 32'h1;
					end
				end
				ST_STAGE2: begin
					if (count <= 32'h1) begin
						state <= ST_DONE;
						count <= 32'h0;
					end else begin
						count <= count - 32'h1;
					end
				end
				ST_IDLE, ST_DONE: begin
					count <= count;
				end
			endcase
		end
	end

	// Output held until arst_n_in reset; reset pulse has fixed length
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			watchdog_out     <= 1'b0;
			module_reset_out <= 1'b0;
			rst_cnt          <= 8'h0;
		end else begin
			if (fire_out) watchdog_out <= 1'b1;
			if (fire_rst) begin
				rst_cnt <= 8'(RESET_PULSE_CYC);
			end else if (rst_cnt != 8'h0) begin
				rst_cnt <= rst_cnt - 8'h1;
			end
			module_reset_out <= fire_rst || (rst_cnt > 8'h1);
		end
	end

	// Register bank; hardware set wins over software clear
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl       <= 32'h0;
			timeout1   <= TIMEOUT_RST;
			timeout2   <= TIMEOUT_RST;
			irq_mask   <= 3'h0;
			irq_status <= 3'h0;
		end else begin
			if (wr_ctrl) ctrl <= merge(ctrl, w_data, w_strb) & 32'h0000_03ff;
			if (wr_t1) timeout1 <= merge(timeout1, w_data, w_strb);
			if (wr_t2) timeout2 <= merge(timeout2, w_data, w_strb);
			if (wr_mask && w_strb[0]) irq_mask <= w_data[2:0];
			irq_status <= (irq_status & ~((wr_irqs && w_strb[0]) ? w_data[2:0] : 3'h0)) | evt;
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(irq_status & irq_mask);
		end
	end

	// Write channel: address and data taken in either order
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			aw_held           <= 1'b0;
			w_held            <= 1'b0;
			aw_addr           <= 8'h0;
			w_data            <= 32'h0;
			w_strb            <= 4'h0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out  <= 1'b1;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_held           <= 1'b1;
				aw_addr           <= {s_axi_awaddr_in[7:2], 2'b00};
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_held           <= 1'b1;
				w_data           <= s_axi_wdata_in;
				w_strb           <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (wr_go) begin
				aw_held          <= 1'b0;
				w_held           <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out  <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out  <= 1'b1;
			end
		end
	end

	wire [7:0]  ra     = {s_axi_araddr_in[7:2], 2'b00};
	wire [31:0] status = {28'h0, watchdog_out, 1'b0, 2'(state)};
	wire        rd_hit = (ra == OFF_CTRL) || (ra == OFF_TIMEOUT1) || (ra == OFF_TIMEOUT2) || (ra == OFF_TRIGGER)
		|| (ra == OFF_STATUS) || (ra == OFF_IRQ_STATUS) || (ra == OFF_IRQ_MASK) || (ra == OFF_COUNT);
	wire [31:0] rd_val = (ra == OFF_CTRL)       ? ctrl :
	                     (ra == OFF_TIMEOUT1)   ? timeout1 :
	                     (ra == OFF_TIMEOUT2)   ? timeout2 :
	                     (ra == OFF_STATUS)     ? status :
	                     (ra == OFF_IRQ_STATUS) ? {29'h0, irq_status} :
	                     (ra == OFF_IRQ_MASK)   ? {29'h0, irq_mask} :
	                     (ra == OFF_COUNT)      ? count : 32'h0;

	// Read channel: one read outstanding
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0;
			s_axi_rresp_out   <= RESP_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b1;
			s_axi_rdata_out   <= rd_val;
			s_axi_rresp_out   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_rvalid_out  <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end
	end
endmodule

// ---- dual_stage_watchdog_asserts.sv ----
// Port checker of the dual stage watchdog
`timescale 1ns/1ns
module dual_stage_watchdog_asserts
	import wdt_pkg::*;
(
	input wire logic        mclk_in,
	input wire logic        arst_n_in,
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic        watchdog_out,
	input wire logic        module_reset_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);
	a_out_after_reset: assert property ($rose(arst_n_in) |-> !watchdog_out)
		else $error("output high after reset");
	a_out_sticky: assert property (!$fell(watchdog_out))
		else $error("output dropped without reset");
	// Two runs of eight, the unroll limit
	a_pulse_len: assert property ($rose(module_reset_out) |-> module_reset_out[*8] ##1 module_reset_out[*8]
		##1 !module_reset_out) else $error("reset pulse length wrong");
	a_b_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped");
	a_r_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped");
	a_aw_blocked: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken while busy");
	a_ar_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read taken while busy");
	a_b_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
		|-> ##[1:2] s_axi_bvalid_out) else $error("write response late");
	a_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read data late");
	cover property ($rose(watchdog_out));
	cover property ($rose(module_reset_out));
	cover property (s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR);
endmodule

// ---- carrier_monitor.sv ----
// Carrier board model watching the watchdog pins
`timescale 1ns/1ns
module carrier_monitor (
	input  wire logic       mclk_in,
	input  wire logic       arst_n_in,
	input  wire logic       watchdog_in,
	input  wire logic       reset_req_in,
	output logic            fired_out,
	output logic      [7:0] pulses_out,
	output logic      [7:0] len_out
);
	logic [7:0] run;
	logic       prev;
	// Latched, so a short glitch still counts as a fire
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fired_out <= 1'b0;
			pulses_out <= 8'h0;
			len_out <= 8'h0;
			run <= 8'h0;
			prev <= 1'b0;
		end else begin
			prev <= reset_req_in;
			fired_out <= fired_out | watchdog_in;
			run <= reset_req_in ? run + 8'h1 : 8'h0;
			if (reset_req_in && !prev) pulses_out <= pulses_out + 8'h1;
			if (!reset_req_in && prev) len_out <= run;
		end
	end
endmodule

// ---- dual_stage_watchdog_tb.sv ----
// Self-checking testbench of the dual stage watchdog
`timescale 1ns/1ns
module dual_stage_watchdog_tb
	import wdt_pkg::*;
;
	logic        mclk_in, arst_n_in, fired;
	logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in, pulses, plen;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
	logic [3:0]  s_axi_wstrb_in;
	logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
	logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
	logic        s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
	logic        s_axi_rvalid_out, s_axi_rready_in, watchdog_out, module_reset_out, irq_out;
	int          mismatches, checked;
	// Off, out, reset, reset+out, delay+out
	// Delay then out, skip to two, two off, out then reset
	// Stage two selected but off, so stage one output stays quiet
	logic [11:0] cases [10] = '{12'h000, 12'h802, 12'h101, 12'h903, 12'hd02,
		12'h586, 12'h097, 12'h054, 12'h813, 12'h804};

	dual_stage_watchdog #(.TICK_DIV(4)) dut (.*);
	carrier_monitor u_carrier (.mclk_in, .arst_n_in, .watchdog_in(watchdog_out),
		.reset_req_in(module_reset_out), .fired_out(fired), .pulses_out(pulses), .len_out(plen));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		do begin
			@(posedge mclk_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end while (s_axi_awvalid_in || s_axi_wvalid_in);
		do @(posedge mclk_in); while (!s_axi_bvalid_out);
		// Late ready also exercises the hold of the response
		s_axi_bready_in <= 1'b1;
		@(posedge mclk_in);
		chk(s_axi_bresp_out, er, "write response");
		s_axi_bready_in <= 1'b0;
		@(posedge mclk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		do @(posedge mclk_in); while (!s_axi_arready_out);
		s_axi_arvalid_in <= 1'b0;
		do @(posedge mclk_in); while (!s_axi_rvalid_out);
		s_axi_rready_in <= 1'b1;
		@(posedge mclk_in);
		chk(s_axi_rdata_out, exp, "read data");
		chk(s_axi_rresp_out, er, "read response");
		s_axi_rready_in <= 1'b0;
		@(posedge mclk_in);
	endtask
	task automatic do_reset();
		arst_n_in <= 1'b0;
		repeat (16) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		@(posedge mclk_in);
	endtask
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	initial begin
		#100us;
		mismatches++;
		final_report();
	end
	initial begin
		logic [11:0] c;
		mismatches = 0;
		checked = 0;
		s_axi_awvalid_in <= 1'b0;
		s_axi_wvalid_in <= 1'b0;
		s_axi_bready_in <= 1'b0;
		s_axi_arvalid_in <= 1'b0;
		s_axi_rready_in <= 1'b0;
		s_axi_awaddr_in <= 8'h0;
		s_axi_araddr_in <= 8'h0;
		s_axi_wdata_in <= 32'h0;
		s_axi_wstrb_in <= 4'hf;
		do_reset();
		rd(OFF_CTRL, 32'h0, RESP_OKAY);
		rd(OFF_TIMEOUT1, TIMEOUT_RST, RESP_OKAY);
		rd(OFF_TIMEOUT2, TIMEOUT_RST, RESP_OKAY);
		rd(8'h20, 32'h0, RESP_SLVERR);
		wr(8'h20, 32'h1, RESP_SLVERR);
		$display("Test registers done");
		foreach (cases[i]) begin
			c = cases[i];
			do_reset();
			chk(watchdog_out, 1'b0, "output after reset");
			wr(OFF_TIMEOUT1, 32'h2, RESP_OKAY);
			wr(OFF_TIMEOUT2, 32'h2, RESP_OKAY);
			wr(OFF_CTRL, {22'h0, 1'b1, c[2], c[7:4], c[11:8]}, RESP_OKAY);
			repeat (120) @(posedge mclk_in);
			chk(fired, c[1], "output action");
			chk(pulses != 8'h0, c[0], "reset action");
			if (c[0]) chk(plen, RESET_PULSE_CYC, "reset pulse length");
		end
		$display("Test action codes done");
		do_reset();
		wr(OFF_IRQ_MASK, 32'h2, RESP_OKAY);
		wr(OFF_TIMEOUT1, 32'h4, RESP_OKAY);
		wr(OFF_CTRL, 32'h0000_0208, RESP_OKAY);
		repeat (8) wr(OFF_TRIGGER, TRIGGER_KEY, RESP_OKAY);
		chk(fired, 1'b0, "fired despite triggers");
		repeat (120) @(posedge mclk_in);
		chk(watchdog_out, 1'b1, "missed trigger");
		chk(irq_out, 1'b1, "irq unmasked");
		rd(OFF_IRQ_STATUS, 32'h0000_0003, RESP_OKAY);
		wr(OFF_IRQ_MASK, 32'h0, RESP_OKAY);
		chk(irq_out, 1'b0, "irq masked");
		wr(OFF_IRQ_STATUS, 32'h7, RESP_OKAY);
		rd(OFF_IRQ_STATUS, 32'h0, RESP_OKAY);
		wr(OFF_IRQ_MASK, 32'h7, RESP_OKAY);
		chk(irq_out, 1'b0, "irq cleared");
		rd(OFF_STATUS, 32'h0000_000b, RESP_OKAY);
		$display("Test trigger and irq done");
		final_report();
	end
endmodule

bind dual_stage_watchdog dual_stage_watchdog_asserts u_asserts (.*);
